// ===== host_io_model.sv
// Host processor model issuing I/O read and write cycles.
`default_nettype none
`include "io_port_watchdog_map.svh"
module host_io_model (
    // clock
    input  wire logic                   clock,
    // host I/O bus
    output logic [`WDG_ADDR_W-1:0]      ioAddr,
    output logic                        ioRead_b,
    output logic                        ioWrite_b
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ioAddr    = 16'h0000;
        ioRead_b  = 1'b1;
        ioWrite_b = 1'b1;
    end
    // address set up early, strobe held 6 cycles, idle 4, then address driven to its complement
    task automatic access(input logic [`WDG_ADDR_W-1:0] addr, input logic rd);
        @(negedge clock) ioAddr = addr;
        repeat (3) @(negedge clock);
        if (rd) ioRead_b = 1'b0;
        else ioWrite_b = 1'b0;
        repeat (6) @(negedge clock);
        ioRead_b  = 1'b1;
        ioWrite_b = 1'b1;
        repeat (4) @(negedge clock);
        ioAddr = ~addr;
    endtask : access
endmodule : host_io_model
`default_nettype wire

// ===== io_port_watchdog.sv
// Watchdog timer controlled by I/O reads of two port addresses.
`default_nettype none
`include "io_port_watchdog_map.svh"
module io_port_watchdog #(
    parameter int unsigned TICK_DIV = `WDG_CLK_HZ / `WDG_TICK_HZ
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst_b,
    input  wire logic                            clockEnable,
    // host I/O bus
    input  wire logic [`WDG_ADDR_W-1:0]          ioAddr,
    input  wire logic                            ioRead_b,
    input  wire logic                            ioWrite_b,
    // static selections
    input  wire io_port_watchdog_pkg::timeout_action_e timeoutActionSelect,
    input  wire logic [3:0]                      timeoutPeriodSelect,
    // outputs to the processor
    output logic                                 systemReset,
    output logic                                 nmi,
    output logic                                 timerEnabled
);
    import io_port_watchdog_pkg::*;

    localparam int unsigned TW = $clog2(TICK_DIV + 1);

    wdg_state_e     state;
    wdg_state_e     next_state;
    logic [TW-1:0]  prescale;
    logic [15:0]    tenths;
    logic [15:0]    limit;
    logic [7:0]     pulseCount;
    logic           readLevel;
    logic           readStrobe;
    logic [`WDG_ADDR_W-1:0] addrHold;
    logic [`WDG_ADDR_W-1:0] addrSync;

    // each address bit crosses from the bus through its own synchroniser
    for (genvar b = 0; b < `WDG_ADDR_W; b++) begin : g_addrSync
        io_strobe_sync addrBitSync (
            .clock       (clock),
            .rst_b       (rst_b),
            .clockEnable (clockEnable),
            .asyncIn     (ioAddr[b]),
            .syncLevel   (addrSync[b]),
            .rise        ()
        );
    end

    // read strobe crosses from the bus; address held when strobe falls
    io_strobe_sync readSync (
        .clock       (clock),
        .rst_b       (rst_b),
        .clockEnable (clockEnable),
        .asyncIn     (!ioRead_b && ioWrite_b),
        .syncLevel   (readLevel),
        .rise        (readStrobe)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            addrHold <= '0;
        end else if (clockEnable && !readLevel) begin
            addrHold <= addrSync;
        end
    end

    wire enrefHit   = readStrobe && (addrHold == `WDG_PORT_ENREF);
    wire disableHit = readStrobe && (addrHold == `WDG_PORT_DISABLE);
    wire actionOff  = (timeoutActionSelect == ACT_OFF);
    wire tick       = (prescale == TW'(TICK_DIV - 1));
    wire expired    = (tenths >= limit) && (state == ST_COUNTING);

    // period table, unknown codes fall back to the shortest period
    always_comb begin
        unique case (timeoutPeriodSelect)
            `WDG_PER_2S:   limit = `WDG_SEC_2;
            `WDG_PER_10S:  limit = `WDG_SEC_10;
            `WDG_PER_20S:  limit = `WDG_SEC_20;
            `WDG_PER_110S: limit = `WDG_SEC_110;
            `WDG_PER_220S: limit = `WDG_SEC_220;
            default:       limit = `WDG_SEC_1;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_DISABLED: if (enrefHit && !actionOff) next_state = ST_COUNTING;
            ST_COUNTING: begin
                if (disableHit || actionOff) begin
                    next_state = ST_DISABLED;
                end else if (expired && !enrefHit) begin
                    next_state = ST_EXPIRED;
                end
            end
            ST_EXPIRED: begin
                if (disableHit || pulseCount == `WDG_RESET_PULSE) begin
                    next_state = ST_DISABLED;
                end
            end
            default: next_state = ST_DISABLED;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_DISABLED;
        end else if (clockEnable) begin
            state <= next_state;
        end
    end

    // tenths-of-a-second count, restarted by any enable or refresh read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= '0;
            tenths   <= '0;
        end else if (clockEnable) begin
            if (state != ST_COUNTING || enrefHit) begin
                prescale <= '0;
                tenths   <= '0;
            end else if (tick) begin
                prescale <= '0;
                tenths   <= tenths + 16'h0001;
            end else begin
                prescale <= prescale + TW'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pulseCount  <= '0;
            systemReset <= 1'b0;
            nmi         <= 1'b0;
        end else if (clockEnable) begin
            pulseCount  <= (state == ST_EXPIRED) ? pulseCount + 8'h01 : 8'h00;
            systemReset <= (next_state == ST_EXPIRED) && (timeoutActionSelect == ACT_RESET);
            nmi         <= (next_state == ST_EXPIRED) && (timeoutActionSelect == ACT_NMI);
        end
    end

    assign timerEnabled = (state == ST_COUNTING);

    AST_DISABLED_AFTER_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        clockEnable && disableHit |=> state == ST_DISABLED)
        else $error("disable read did not stop the timer");
    AST_START_ON_ENABLE: assert property (@(posedge clock) disable iff (!rst_b)
        clockEnable && state == ST_DISABLED && enrefHit && !actionOff
        |=> state == ST_COUNTING)
        else $error("enable read did not start the timer");
    AST_REFRESH_CLEARS: assert property (@(posedge clock) disable iff (!rst_b)
        clockEnable && state == ST_COUNTING && enrefHit && !disableHit && !actionOff
        |=> tenths == 16'h0000 && state == ST_COUNTING)
        else $error("refresh did not restart the count");
    sequence s_expiry;
        clockEnable && state == ST_COUNTING && expired && !enrefHit && !disableHit && !actionOff;
    endsequence
    AST_ACTION_ON_EXPIRY: assert property (@(posedge clock) disable iff (!rst_b)
        s_expiry |=> (systemReset || nmi) && state == ST_EXPIRED)
        else $error("expiry produced no action");
    AST_OFF_NO_ACTION: assert property (@(posedge clock) disable iff (!rst_b)
        actionOff |=> !systemReset && !nmi)
        else $error("action off still produced an output");
    AST_NO_ACTION_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
        state == ST_DISABLED && $past(state) == ST_DISABLED |-> !systemReset && !nmi)
        else $error("action while timer disabled");
    AST_DEFAULT_PERIOD: assert property (@(posedge clock) disable iff (!rst_b)
        timeoutPeriodSelect == `WDG_PER_1S |-> limit == `WDG_SEC_1)
        else $error("one second period wrong");
    AST_WRITE_IGNORED: assert property (@(posedge clock) disable iff (!rst_b)
        !ioWrite_b [*4] |-> !readStrobe)
        else $error("write cycle acted as a read");
endmodule : io_port_watchdog
`default_nettype wire

// ===== io_port_watchdog_map.svh
// Address, selection and timing constants of the I/O port watchdog.
`ifndef IO_PORT_WATCHDOG_MAP_SVH
`define IO_PORT_WATCHDOG_MAP_SVH
`define WDG_ADDR_W          16
`define WDG_PORT_DISABLE    16'h0043
`define WDG_PORT_ENREF      16'h0443
`define WDG_CLK_HZ          10000000
`define WDG_TICK_HZ         10
`define WDG_PER_1S          4'h2
`define WDG_PER_2S          4'h3
`define WDG_PER_10S         4'h4
`define WDG_PER_20S         4'h5
`define WDG_PER_110S        4'h8
`define WDG_PER_220S        4'h9
`define WDG_SEC_1           16'h000A
`define WDG_SEC_2           16'h0014
`define WDG_SEC_10          16'h0064
`define WDG_SEC_20          16'h00C8
`define WDG_SEC_110         16'h044C
`define WDG_SEC_220         16'h0898
`define WDG_RESET_PULSE     8'h10
`endif

// ===== io_port_watchdog_pkg.sv
// Types shared by the I/O port watchdog files.
`default_nettype none
package io_port_watchdog_pkg;
    typedef enum logic [1:0] {
        ACT_RESET   = 2'b00,
        ACT_NMI     = 2'b01,
        ACT_OFF     = 2'b10
    } timeout_action_e;
    typedef enum logic [1:0] {
        ST_DISABLED = 2'b00,
        ST_COUNTING = 2'b01,
        ST_EXPIRED  = 2'b10
    } wdg_state_e;
endpackage : io_port_watchdog_pkg
`default_nettype wire

// ===== io_strobe_sync.sv
// Three-stage synchroniser with agreement detection for an outside level.
`default_nettype none
module io_strobe_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic clockEnable,
    // level in and out
    input  wire logic asyncIn,
    output logic      syncLevel,
    output logic      rise
);
    logic stage1;
    logic stage2;
    logic stage3;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            syncLevel <= 1'b0;
        end else if (clockEnable) begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                syncLevel <= stage3;
            end
        end
    end
    // one pulse when the agreed level turns high
    assign rise = clockEnable && (stage2 == stage3) && stage3 && !syncLevel;
endmodule : io_strobe_sync
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the I/O port watchdog.
`default_nettype none
`include "io_port_watchdog_map.svh"
module testbench;
    import io_port_watchdog_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TD = 10;
    localparam logic [3:0] PCODE [6] = '{`WDG_PER_1S, `WDG_PER_2S, `WDG_PER_10S,
                                        `WDG_PER_20S, `WDG_PER_110S, `WDG_PER_220S};
    localparam int TEN [6] = '{10, 20, 100, 200, 1100, 2200};
    logic            clock = 1'b0;
    logic            rst_b = 1'b0;
    logic            hit   = 1'b0;
    logic            ce    = 1'b1;
    timeout_action_e act   = ACT_RESET;
    logic [3:0]      per   = `WDG_PER_1S;
    wire logic [15:0] ioAddr;
    wire logic       ioRead_b;
    wire logic       ioWrite_b;
    logic            systemReset;
    logic            nmi;
    logic            timerEnabled;
    int              error_cnt = 0;
    int              tests_run = 0;
    always #50 clock = ~clock;
    always @(posedge clock) if (systemReset === 1'b1 || nmi === 1'b1) hit = 1'b1;
    host_io_model HOST (.clock(clock), .ioAddr(ioAddr), .ioRead_b(ioRead_b),
                        .ioWrite_b(ioWrite_b));
    io_port_watchdog #(.TICK_DIV(TD)) DUT (.clock(clock), .rst_b(rst_b),
        .clockEnable(ce), .ioAddr(ioAddr), .ioRead_b(ioRead_b), .ioWrite_b(ioWrite_b),
        .timeoutActionSelect(act), .timeoutPeriodSelect(per), .systemReset(systemReset),
        .nmi(nmi), .timerEnabled(timerEnabled));
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    // enable, let it run out, measure the time to the action
    task automatic run_out(input logic [3:0] p, input int tn, input timeout_action_e a);
        int n;
        n   = 0;
        per = p;
        act = a;
        HOST.access(`WDG_PORT_ENREF, 1'b1);
        check("enabled", 1, timerEnabled);
        while (systemReset !== 1'b1 && nmi !== 1'b1 && n < tn * TD + 40) begin
            @(negedge clock);
            n++;
        end
        check("expiry time", 1, n >= tn * TD - TD - 12 && n <= tn * TD + TD);
        check("reset line", a == ACT_RESET, systemReset);
        check("nmi line", a == ACT_NMI, nmi);
        if (n >= tn * TD + 40) test_done();
        repeat (20) @(negedge clock);
        check("after action", 0, {systemReset, nmi, timerEnabled});
        $display("test expiry %0d done", tn);
    endtask : run_out
    task automatic t_refresh;
        act = ACT_RESET;
        per = `WDG_PER_1S;
        hit = 1'b0;
        HOST.access(`WDG_PORT_ENREF, 1'b1);
        repeat (4) begin
            repeat (60) @(negedge clock);
            HOST.access(`WDG_PORT_ENREF, 1'b1);
        end
        check("refreshed", 2'b01, {hit, timerEnabled});
        HOST.access(`WDG_PORT_DISABLE, 1'b1);
        check("disabled", 0, timerEnabled);
        repeat (150) @(negedge clock);
        check("no action", 0, hit);
        $display("test refresh done");
    endtask : t_refresh
    task automatic t_ignored;
        hit = 1'b0;
        HOST.access(`WDG_PORT_ENREF, 1'b0);
        HOST.access(16'h0444, 1'b1);
        act = ACT_OFF;
        HOST.access(`WDG_PORT_ENREF, 1'b1);
        repeat (150) @(negedge clock);
        check("ignored", 0, {hit, timerEnabled});
        $display("test ignored done");
    endtask : t_ignored
    // enable low freezes the count, so no action however long it stays low
    task automatic t_freeze;
        act = ACT_RESET;
        per = `WDG_PER_1S;
        hit = 1'b0;
        HOST.access(`WDG_PORT_ENREF, 1'b1);
        ce = 1'b0;
        repeat (300) @(negedge clock);
        check("frozen", 2'b01, {hit, timerEnabled});
        ce = 1'b1;
        HOST.access(`WDG_PORT_DISABLE, 1'b1);
        check("thawed disable", 0, {hit, timerEnabled});
        $display("test freeze done");
    endtask : t_freeze
    initial begin
        #10ms;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        repeat (150) @(negedge clock);
        check("idle after reset", 0, {hit, timerEnabled, systemReset, nmi});
        $display("test power-on done");
        for (int i = 0; i < 6; i++) run_out(PCODE[i], TEN[i], ACT_RESET);
        run_out(`WDG_PER_2S, 20, ACT_NMI);
        t_refresh();
        t_freeze();
        t_ignored();
        test_done();
    end
endmodule : testbench
`default_nettype wire
